// >>> eps_pkg.sv
// shared constants and types for the encoder position scaling block
package eps_pkg;
  // ****************************************************************
  // resolution and datapath widths
  // ****************************************************************
  localparam int ST_BITS   = 13;   // physical singleturn bits
  localparam int MT_BITS   = 12;   // physical multiturn bits
  localparam int DIV_W     = 40;   // divider operand width

  // ****************************************************************
  // register byte offsets
  // ****************************************************************
  localparam logic [11:0] REG_CTRL   = 12'h000;
  localparam logic [11:0] REG_UPR    = 12'h004;
  localparam logic [11:0] REG_RANGE  = 12'h008;
  localparam logic [11:0] REG_MAXSOL = 12'h00C;
  localparam logic [11:0] REG_VELU   = 12'h010;
  localparam logic [11:0] REG_TGRAM  = 12'h014;
  localparam logic [11:0] REG_STATUS = 12'h018;
  localparam logic [11:0] REG_POS    = 12'h01C;
  localparam logic [11:0] REG_VEL    = 12'h020;
  localparam logic [11:0] REG_RZONE  = 12'h024;
  localparam logic [11:0] REG_PROF   = 12'h028;
  localparam logic [11:0] REG_REVS   = 12'h02C;

  // ****************************************************************
  // field positions and reset values
  // ****************************************************************
  localparam int CTL_CODESEQ = 0;
  localparam int CTL_CLASS4  = 1;
  localparam int CTL_PRESET  = 2;
  localparam int CTL_SCALE   = 3;
  localparam int CTL_ALARM   = 4;
  localparam int CTL_COMPAT  = 5;
  localparam int CTL_LSMON   = 8;
  localparam logic [8:0]  CTRL_RST   = 9'h122;
  localparam logic        COMPAT_ON  = 1'b0;
  localparam int ST_SOLF  = 0;
  localparam int ST_CREQ  = 1;
  localparam int ST_DCWV  = 2;
  localparam int ST_ALARM = 3;

  // ****************************************************************
  // parameter limits and codes
  // ****************************************************************
  localparam logic [7:0]  PROFILE_COMPAT = 8'h1F;  // 31
  localparam logic [7:0]  PROFILE_NEW    = 8'h29;  // 41
  localparam logic [31:0] UPR_MIN    = 32'h0000_0001;
  localparam logic [31:0] RANGE_MIN  = 32'h0000_0002;
  localparam logic [31:0] SOL_MIN    = 32'h0000_0001;
  localparam logic [31:0] SOL_MAX    = 32'h0000_00FF;
  localparam logic [7:0]  SOL_RST    = 8'h01;
  localparam logic [31:0] VELU_MAX   = 32'h0000_0003;
  localparam logic [7:0]  TGRAM_NOVEL = 8'h51;     // 81
  localparam logic [7:0]  TGRAM_MAX   = 8'h54;     // 84
  localparam logic [1:0]  VELU_SPS   = 2'h0;
  localparam logic [1:0]  VELU_S100  = 2'h1;
  localparam logic [1:0]  VELU_S10   = 2'h2;
  localparam logic [1:0]  VELU_RPM   = 2'h3;
  localparam logic [9:0]  VEL_MUL_SPS = 10'h00A;   // x10
  localparam logic [9:0]  VEL_DIV_S10 = 10'h00A;   // /10
  localparam logic [9:0]  VEL_MUL_RPM = 10'h258;   // x600

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int CLK_KHZ       = 250000;
  localparam int VEL_PERIOD_MS = 100;
  localparam int VEL_CYCLES    = VEL_PERIOD_MS * CLK_KHZ;

  typedef enum logic [2:0] {
    EPS_IDLE  = 3'b000,
    EPS_SCALE = 3'b001,
    EPS_MOD   = 3'b010,
    EPS_RZ    = 3'b011,
    EPS_REV   = 3'b100,
    EPS_VEL   = 3'b101
  } eps_state_e;
endpackage

// >>> eps_div_if.sv
// request and answer wires between the scaler and its divider
`timescale 1ns/1ps
interface eps_div_if #(parameter int W = 40);
  logic         start;
  logic [W-1:0] dividend;
  logic [W-1:0] divisor;
  logic         done;
  logic [W-1:0] quotient;
  logic [W-1:0] remainder;
  modport master (output start, dividend, divisor, input done, quotient, remainder);
  modport slave  (input start, dividend, divisor, output done, quotient, remainder);
endinterface

// >>> eps_divider.sv
// restoring divider, one quotient bit per clock
`timescale 1ns/1ps
module eps_divider #(
  parameter int W = 40
) (
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // operation port
  eps_div_if.slave  dv
);
  localparam int CW = $clog2(W + 1);

  logic [W-1:0]  rem;
  logic [W-1:0]  quo;
  logic [W-1:0]  dvs;
  logic [CW-1:0] cnt;
  logic          busy;
  logic          done;

  // trial subtraction of the shifted partial remainder
  wire  [W:0]    r_shift = {rem, quo[W-1]};
  wire           fits    = r_shift >= {1'b0, dvs};
  wire  [W:0]    r_sub   = r_shift - {1'b0, dvs};

  assign dv.done      = done;
  assign dv.quotient  = quo;
  assign dv.remainder = rem;

  // a start while busy is dropped; the scaler never issues one
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rem  <= '0;
      quo  <= '0;
      dvs  <= '0;
      cnt  <= '0;
      busy <= 1'b0;
      done <= 1'b0;
    end
    else if (dv.start && !busy)
    begin
      rem  <= '0;
      quo  <= dv.dividend;
      dvs  <= dv.divisor;
      cnt  <= '0;
      busy <= 1'b1;
      done <= 1'b0;
    end
    else if (busy)
    begin
      rem  <= fits ? r_sub[W-1:0] : r_shift[W-1:0];
      quo  <= {quo[W-2:0], fits};
      cnt  <= cnt + 1'b1;
      busy <= (cnt != CW'(W - 1));
      done <= (cnt == CW'(W - 1));
    end
    else
    begin
      done <= 1'b0;
    end
  end
endmodule // eps_divider

// >>> eps_position_scaling.sv
// encoder parameter handling, position scaling, velocity and life-sign supervision
`timescale 1ns/1ps
// Functional notes
// - compatibility bit 0 means old-profile behaviour, 1 means new profile only
// - compat on: control request ignored, control word valid, requested bit 0
// - compat off: limit ignored, one missed life sign tolerated, monitor optional
// - compat off: alarm channel always active, alarm control bit ignored
// - profile number reads 31 in compat mode, otherwise 41
// - scaling only applies when class 4 and scaling enable are both set
// - position converted to user resolution; settings capped at physical resolution
// - units per revolution accepted 1 to counts per rev, default counts per rev
// - total range accepted 2 to full physical resolution, defaults to it
// - revolutions equal total range divided by units per revolution
// - red zone is physical resolution modulo set total range
// - physical wrap inside red zone makes scaled position jump to 0
// - compat on: life-sign limit 1 to 255, default 1, fault when exceeded
// - velocity unit code 0..3: steps/s, steps/100ms, steps/10ms, rpm
// - telegram 81 carries no velocity; 82 to 84 carry scaled velocity
// - velocity recomputed every 100 ms regardless of unit
// - scaling off uses physical resolutions; on uses configured values
// - with class 4 set, count direction 0 counts up clockwise, 1 counts up counter-clockwise; ignored without class 4
module eps_position_scaling
  import eps_pkg::*;
#(
  parameter int ST     = eps_pkg::ST_BITS,
  parameter int MT     = eps_pkg::MT_BITS,
  parameter int VEL_CY = eps_pkg::VEL_CYCLES
) (
  // clock and reset
  input  wire logic               pclk,
  input  wire logic               presetn,
  // apb slave
  input  wire logic [11:0]        paddr,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [31:0]        pwdata,
  output logic                    pready,
  output logic [31:0]             prdata,
  output logic                    pslverr,
  // sensor and cyclic telegram side
  input  wire logic [ST+MT-1:0]   phys_pos,
  input  wire logic               sol_tick,
  input  wire logic               sol_ok,
  input  wire logic               ctl_request,
  // results
  output logic [ST+MT-1:0]        pos_scaled,
  output logic [15:0]             velocity_out_short,
  output logic [31:0]             velocity_out_long,
  output logic                    control_requested,
  output logic                    drive_control_valid,
  output logic                    alarm_channel_active,
  output logic                    sol_fault,
  output logic [7:0]              profile_number_param
);
  localparam int TOT = ST + MT;
  localparam int VCW = $clog2(VEL_CY);
  localparam logic [ST:0]  CPR     = (ST+1)'(1) << ST;
  localparam logic [TOT:0] TOT_CNT = (TOT+1)'(1) << TOT;

  // ****************************************************************
  // helper functions
  // ****************************************************************
  function automatic logic [9:0] vel_mul(input logic [1:0] u);
    return (u == VELU_SPS) ? VEL_MUL_SPS : (u == VELU_RPM) ? VEL_MUL_RPM : 10'h001;
  endfunction

  function automatic logic [ST:0] vel_dvs(input logic [1:0] u);
    return (u == VELU_S10) ? (ST+1)'(VEL_DIV_S10) : (u == VELU_RPM) ? CPR : (ST+1)'(1);
  endfunction

  function automatic logic [15:0] sat16(input logic [31:0] v);
    if (!v[31] && v[30:15] != 16'h0000)
      return 16'h7FFF;
    else if (v[31] && v[30:15] != 16'hFFFF)
      return 16'h8000;
    else
      return v[15:0];
  endfunction

  // ****************************************************************
  // registers
  // ****************************************************************
  logic [8:0]     ctrl;
  logic [ST:0]    upr;
  logic [TOT:0]   range_set;
  logic [7:0]     max_sol;
  logic [1:0]     velu;
  logic [7:0]     tgram;
  logic [TOT:0]   red_zone;
  logic [TOT:0]   revs;
  logic [8:0]     miss_cnt;
  logic [VCW-1:0] vel_cnt;
  logic           vel_tick;
  logic           vel_pend;
  logic [TOT-1:0] vel_prev;
  logic [TOT-1:0] vel_mag;
  logic           vel_neg;
  logic [31:0]    vel_raw;
  logic [ST:0]    upr_lat;
  logic [TOT:0]   range_lat;
  eps_state_e     state;
  eps_state_e     next_state;

  eps_div_if #(.W(DIV_W)) dv ();

  eps_divider #(.W(DIV_W)) u_div (
    .pclk    (pclk),
    .presetn (presetn),
    .dv      (dv)
  );

  // ****************************************************************
  // mode decode
  // ****************************************************************
  wire compat_on = (ctrl[CTL_COMPAT] == COMPAT_ON);
  wire class4    = ctrl[CTL_CLASS4];
  wire scale_on  = class4 & ctrl[CTL_SCALE];
  wire [ST:0]    eff_upr   = scale_on ? upr : CPR;
  wire [TOT:0]   eff_range = scale_on ? range_set : TOT_CNT;
  wire [TOT-1:0] pos_dir   = (class4 && ctrl[CTL_CODESEQ]) ? ~phys_pos : phys_pos;
  wire [TOT-1:0] vel_delta = pos_dir - vel_prev;

  // ****************************************************************
  // apb decode
  // ****************************************************************
  wire sel_ctrl   = (paddr == REG_CTRL);
  wire sel_upr    = (paddr == REG_UPR);
  wire sel_range  = (paddr == REG_RANGE);
  wire sel_maxsol = (paddr == REG_MAXSOL);
  wire sel_velu   = (paddr == REG_VELU);
  wire sel_tgram  = (paddr == REG_TGRAM);
  wire sel_status = (paddr == REG_STATUS);
  wire sel_ro     = (paddr == REG_POS) | (paddr == REG_VEL) | (paddr == REG_RZONE) |
                    (paddr == REG_PROF) | (paddr == REG_REVS);
  wire mapped     = sel_ctrl | sel_upr | sel_range | sel_maxsol | sel_velu |
                    sel_tgram | sel_status | sel_ro;
  // out-of-range settings are refused with an error and leave the old value
  wire bad_val    = (sel_upr && (pwdata < UPR_MIN || pwdata > 32'(CPR))) |
                    (sel_range && (pwdata < RANGE_MIN || pwdata > 32'(TOT_CNT))) |
                    (sel_maxsol && (pwdata < SOL_MIN || pwdata > SOL_MAX)) |
                    (sel_velu && pwdata > VELU_MAX) |
                    (sel_tgram && (pwdata < 32'(TGRAM_NOVEL) || pwdata > 32'(TGRAM_MAX)));
  wire acc_err    = !mapped | (pwrite & bad_val);
  wire wr_ok      = psel & penable & pready & pwrite & !pslverr;
  wire [31:0] status_word = {28'h0, alarm_channel_active, drive_control_valid,
                             control_requested, sol_fault};
  wire [31:0] rd_mux =
    sel_ctrl   ? {23'h0, ctrl} :
    sel_upr    ? 32'(upr) :
    sel_range  ? 32'(range_set) :
    sel_maxsol ? {24'h0, max_sol} :
    sel_velu   ? {30'h0, velu} :
    sel_tgram  ? {24'h0, tgram} :
    sel_status ? status_word :
    (paddr == REG_POS)   ? 32'(pos_scaled) :
    (paddr == REG_VEL)   ? velocity_out_long :
    (paddr == REG_RZONE) ? 32'(red_zone) :
    (paddr == REG_PROF)  ? {24'h0, profile_number_param} :
    (paddr == REG_REVS)  ? 32'(revs) : 32'h0000_0000;

  // one wait state: answer is registered in the first access cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= psel & penable & !pready;
      prdata  <= (psel & penable & !pready & !pwrite) ? rd_mux : 32'h0000_0000;
      pslverr <= psel & penable & !pready & acc_err;
    end
  end

  // setting registers; scaling changes do not move the reference point
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl      <= CTRL_RST;
      upr       <= CPR;
      range_set <= TOT_CNT;
      max_sol   <= SOL_RST;
      velu      <= VELU_SPS;
      tgram     <= TGRAM_NOVEL;
    end
    else if (wr_ok)
    begin
      if (sel_ctrl)   ctrl      <= pwdata[8:0];
      if (sel_upr)    upr       <= pwdata[ST:0];
      if (sel_range)  range_set <= pwdata[TOT:0];
      if (sel_maxsol) max_sol   <= pwdata[7:0];
      if (sel_velu)   velu      <= pwdata[1:0];
      if (sel_tgram)  tgram     <= pwdata[7:0];
    end
  end

  // ****************************************************************
  // mode outputs and life-sign supervision
  // ****************************************************************
  wire [8:0] sol_limit = compat_on ? {1'b0, max_sol} : 9'h001;
  wire       sol_sup   = compat_on | ctrl[CTL_LSMON];
  wire       sol_set   = sol_sup & (miss_cnt > sol_limit);
  wire       sol_clr   = wr_ok & sel_status & pwdata[ST_SOLF];

  // a new fault in the clearing cycle survives the clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      miss_cnt             <= 9'h000;
      sol_fault            <= 1'b0;
      control_requested    <= 1'b0;
      drive_control_valid  <= 1'b0;
      alarm_channel_active <= 1'b0;
      profile_number_param <= PROFILE_NEW;
    end
    else
    begin
      if (sol_tick)
        miss_cnt <= sol_ok ? 9'h000 : (miss_cnt == 9'h1FF) ? miss_cnt : miss_cnt + 9'h001;
      sol_fault            <= sol_set | (sol_fault & !sol_clr);
      control_requested    <= !compat_on & ctl_request;
      drive_control_valid  <= compat_on | ctl_request;
      alarm_channel_active <= compat_on ? ctrl[CTL_ALARM] : 1'b1;
      profile_number_param <= compat_on ? PROFILE_COMPAT : PROFILE_NEW;
    end
  end

  // ****************************************************************
  // velocity timebase and sampling
  // ****************************************************************
  // sample the shaft every period, independent of the unit code
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      vel_cnt  <= '0;
      vel_tick <= 1'b0;
      vel_pend <= 1'b0;
      vel_prev <= '0;
      vel_mag  <= '0;
      vel_neg  <= 1'b0;
    end
    else
    begin
      vel_tick <= (vel_cnt == VCW'(VEL_CY - 1));
      vel_cnt  <= (vel_cnt == VCW'(VEL_CY - 1)) ? '0 : vel_cnt + 1'b1;
      vel_pend <= vel_tick | (vel_pend & !(state == EPS_REV && dv.done));
      if (vel_tick)
      begin
        vel_prev <= pos_dir;
        vel_neg  <= vel_delta[TOT-1];
        vel_mag  <= vel_delta[TOT-1] ? (~vel_delta + 1'b1) : vel_delta;
      end
    end
  end

  // ****************************************************************
  // computation sequencer
  // ****************************************************************
  assign dv.start = (state == EPS_IDLE) ||
                    (dv.done && state != EPS_VEL && !(state == EPS_REV && !vel_pend));
  assign dv.dividend =
    (state == EPS_IDLE)  ? DIV_W'(pos_dir) * DIV_W'(eff_upr) :
    (state == EPS_SCALE) ? dv.quotient :
    (state == EPS_MOD)   ? DIV_W'(TOT_CNT) :
    (state == EPS_RZ)    ? DIV_W'(range_lat) :
    DIV_W'(vel_mag) * DIV_W'(vel_mul(velu));
  assign dv.divisor =
    (state == EPS_IDLE)  ? DIV_W'(CPR) :
    (state == EPS_RZ)    ? DIV_W'(upr_lat) :
    (state == EPS_REV)   ? DIV_W'(vel_dvs(velu)) :
    DIV_W'(range_lat);

  always_comb
  begin
    next_state = state;
    unique case (state)
      EPS_IDLE:  next_state = EPS_SCALE;
      EPS_SCALE: if (dv.done) next_state = EPS_MOD;
      EPS_MOD:   if (dv.done) next_state = EPS_RZ;
      EPS_RZ:    if (dv.done) next_state = EPS_REV;
      EPS_REV:   if (dv.done) next_state = vel_pend ? EPS_VEL : EPS_IDLE;
      EPS_VEL:   if (dv.done) next_state = EPS_IDLE;
      default:   next_state = EPS_IDLE;
    endcase
  end

  // the modulo step makes a wrap inside the red zone land on zero
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state      <= EPS_IDLE;
      upr_lat    <= CPR;
      range_lat  <= TOT_CNT;
      pos_scaled <= '0;
      red_zone   <= '0;
      revs       <= '0;
      vel_raw    <= 32'h0000_0000;
    end
    else
    begin
      state <= next_state;
      if (state == EPS_IDLE)
      begin
        upr_lat   <= eff_upr;
        range_lat <= eff_range;
      end
      if (dv.done && state == EPS_MOD)
        pos_scaled <= dv.remainder[TOT-1:0];
      if (dv.done && state == EPS_RZ)
        red_zone <= dv.remainder[TOT:0];
      if (dv.done && state == EPS_REV)
        revs <= dv.quotient[TOT:0];
      if (dv.done && state == EPS_VEL)
        vel_raw <= vel_neg ? (32'h0 - dv.quotient[31:0]) : dv.quotient[31:0];
    end
  end

  // velocity outputs are blanked for the position-only telegram
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      velocity_out_long  <= 32'h0000_0000;
      velocity_out_short <= 16'h0000;
    end
    else
    begin
      velocity_out_long  <= (tgram == TGRAM_NOVEL) ? 32'h0000_0000 : vel_raw;
      velocity_out_short <= (tgram == TGRAM_NOVEL) ? 16'h0000 : sat16(vel_raw);
    end
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_compat_no_creq: assert property (compat_on |=> !control_requested)
    else $error("control requested set in compat mode");
  a_new_dcw_follow: assert property (!compat_on && !ctl_request |=> !drive_control_valid ||
                                     $past(compat_on))
    else $error("control word valid without request");
  a_alarm_forced: assert property (!compat_on |=> alarm_channel_active)
    else $error("alarm channel inactive outside compat mode");
  a_profile_value: assert property (##1 profile_number_param ==
                                    ($past(compat_on) ? PROFILE_COMPAT : PROFILE_NEW))
    else $error("profile number wrong");
  a_sol_single: assert property (!compat_on && ctrl[CTL_LSMON] && miss_cnt == 9'h002
                                 |=> sol_fault)
    else $error("second missed life sign not faulted");
  a_sol_limit: assert property (compat_on && miss_cnt <= {1'b0, max_sol} && !sol_fault
                                && $stable(ctrl) ##1 $stable(ctrl) |-> !sol_fault)
    else $error("life-sign fault below limit");
  a_pos_bound: assert property (state == EPS_MOD && dv.done
                                |=> {1'b0, pos_scaled} < range_lat)
    else $error("scaled position not below range");
  a_upr_legal: assert property (upr >= (ST+1)'(1) && upr <= CPR)
    else $error("units per revolution out of range");
  a_range_legal: assert property (range_set >= (TOT+1)'(2) && range_set <= TOT_CNT)
    else $error("total range out of range");
  a_vel_blank: assert property (tgram == TGRAM_NOVEL |=> velocity_out_long == 32'h0)
    else $error("velocity present in telegram 81");
  a_apb_wait: assert property (psel && penable && !pready |=> pready ##1 !pready)
    else $error("apb answer timing wrong");
endmodule // eps_position_scaling

// >>> eps_plc_model.sv
// controller-side model: life-sign beats and the control request level
`timescale 1ns/1ps
module eps_plc_model (
  // clock
  input  wire logic pclk,
  // cyclic telegram side
  output logic      sol_tick,
  output logic      sol_ok,
  output logic      ctl_request
);
  initial {sol_tick, sol_ok, ctl_request} = 3'b000;
  // one life-sign slot; ok is inverted outside the slot so no stale value is seen
  task automatic beat(input logic good);
    sol_tick <= 1'b1;
    sol_ok   <= good;
    @(posedge pclk);
    sol_tick <= 1'b0;
    sol_ok   <= ~good;
    repeat (3) @(posedge pclk);
  endtask
  // level of the control-request bit
  task automatic request(input logic v);
    ctl_request <= v;
    repeat (3) @(posedge pclk);
  endtask
endmodule // eps_plc_model

// >>> encoder_position_scaling_tb.sv
// self-checking bench for the encoder position scaling block
`timescale 1ns/1ps
module encoder_position_scaling_tb;
  import eps_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel, penable, pwrite, run = 1'b0;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, velocity_out_long, r;
  logic [24:0] phys_pos, pset, pos_scaled;
  logic        pready, pslverr, e, control_requested, drive_control_valid, alarm_channel_active;
  logic        sol_fault, sol_tick, sol_ok, ctl_request;
  logic [15:0] velocity_out_short;
  logic [7:0]  profile_number_param;
  logic [31:0] vexp [4] = '{32'hFA0, 32'h190, 32'h28, 32'h1D};
  int n_fail = 0, n_tests = 0;
  always #2 pclk = ~pclk;
  // shaft turning one step per clock while run is set, else parked at pset
  always @(posedge pclk) phys_pos <= run ? phys_pos + 25'h1 : pset;
  eps_position_scaling #(.VEL_CY(400)) i_dut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata,
    .pready, .prdata, .pslverr, .phys_pos, .sol_tick, .sol_ok, .ctl_request, .pos_scaled, .velocity_out_short,
    .velocity_out_long, .control_requested, .drive_control_valid, .alarm_channel_active, .sol_fault,
    .profile_number_param);
  eps_plc_model i_plc (.pclk, .sol_tick, .sol_ok, .ctl_request);
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // apb transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk) penable <= 1'b1;
    // only the watchdog ends a wait that never sees pready
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic xe);
    apb(1'b1, a, d);
    chk({31'h0, e}, {31'h0, xe});
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(r, x);
  endtask
  // settle the scaling sequence, then compare the scaled position
  task automatic pc(input logic [24:0] p, input logic [24:0] x);
    pset <= p;
    repeat (400) @(posedge pclk);
    chk(pos_scaled, x);
  endtask
  initial
  begin
    #200000 n_fail++;
    report_and_stop();
  end
  initial
  begin
    {psel, penable, pwrite, paddr, pwdata, pset} <= '0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(REG_CTRL, 32'h122);
    rd(REG_UPR, 32'h2000);
    rd(REG_RANGE, 32'h200_0000);
    rd(REG_MAXSOL, 32'h1);
    rd(REG_VELU, 32'h0);
    rd(REG_PROF, 32'h29);
    wr(REG_UPR, 32'h0, 1'b1);
    wr(REG_UPR, 32'h2001, 1'b1);
    wr(REG_RANGE, 32'h1, 1'b1);
    wr(REG_RANGE, 32'h200_0001, 1'b1);
    wr(REG_MAXSOL, 32'h100, 1'b1);
    wr(REG_VELU, 32'h4, 1'b1);
    wr(12'h030, 32'h0, 1'b1);
    rd(REG_UPR, 32'h2000);
    $display("test defaults and limits done");
    i_plc.request(1'b1);
    chk(control_requested, 1'b1);
    chk(alarm_channel_active, 1'b1);
    wr(REG_CTRL, 32'h102, 1'b0);
    i_plc.request(1'b1);
    chk(control_requested, 1'b0);
    i_plc.request(1'b0);
    chk(drive_control_valid, 1'b1);
    chk(alarm_channel_active, 1'b0);
    rd(REG_PROF, 32'h1F);
    chk(profile_number_param, 8'h1F);
    wr(REG_MAXSOL, 32'h3, 1'b0);
    repeat (3) i_plc.beat(1'b0);
    chk(sol_fault, 1'b0);
    i_plc.beat(1'b0);
    chk(sol_fault, 1'b1);
    i_plc.beat(1'b1);
    wr(REG_CTRL, 32'h122, 1'b0);
    wr(REG_STATUS, 32'h1, 1'b0);
    i_plc.beat(1'b0);
    chk(sol_fault, 1'b0);
    i_plc.beat(1'b0);
    chk(sol_fault, 1'b1);
    chk(drive_control_valid, 1'b0);
    $display("test compatibility and life sign done");
    wr(REG_UPR, 32'h1000, 1'b0);
    wr(REG_RANGE, 32'h3000, 1'b0);
    wr(REG_CTRL, 32'h12E, 1'b0);
    pc(25'h00A064, 25'h002032);
    pc(25'h1FF_FFFF, 25'h000FFF);
    pc(25'h0, 25'h0);
    rd(REG_RZONE, 32'h2000);
    rd(REG_REVS, 32'h3);
    wr(REG_CTRL, 32'h12F, 1'b0);
    pc(25'h0, 25'h000FFF);
    wr(REG_CTRL, 32'h128, 1'b0);
    pc(25'h00A064, 25'h00A064);
    $display("test scaling done");
    wr(REG_CTRL, 32'h122, 1'b0);
    wr(REG_TGRAM, 32'h52, 1'b0);
    run <= 1'b1;
    for (int u = 0; u < 4; u++)
    begin
      wr(REG_VELU, u, 1'b0);
      repeat (900) @(posedge pclk);
      chk(velocity_out_long, vexp[u]);
      chk({16'h0, velocity_out_short}, vexp[u]);
    end
    rd(REG_VEL, 32'h1D);
    wr(REG_TGRAM, 32'h51, 1'b0);
    repeat (900) @(posedge pclk);
    chk(velocity_out_long, 32'h0);
    chk({16'h0, velocity_out_short}, 32'h0);
    $display("test velocity done");
    report_and_stop();
  end
endmodule // encoder_position_scaling_tb
